// [core/boundary_scan_test_port.v]
`timescale 1ns/1ps
`include "tap_regs.vh"
module boundary_scan_test_port (
   input  wire                    clk,
   input  wire                    resetn,
   input  wire                    tck,
   input  wire                    tms,
   input  wire                    tdi,
   output reg                     tdo_ff,
   output reg                     tdo_oe_ff,
   input  wire [`NUM_PINS-1:0]    pin_in,
   input  wire [`NUM_PINS-1:0]    core_out,
   input  wire [`NUM_PINS-1:0]    core_oe,
   input  wire [`NUM_PINS-1:0]    hold_en,
   output reg  [`NUM_PINS-1:0]    pad_out_ff,
   output reg  [`NUM_PINS-1:0]    pad_oe_ff,
   output reg  [`NUM_PINS-1:0]    pad_keep_ff,
   output reg  [`NUM_PINS-1:0]    io_std_ff,
   output reg  [`PLL_BITS-1:0]    pll_cfg_ff,
   input  wire                    config_done,
   input  wire                    config_busy,
   input  wire [31:0]             user_code,
   output reg                     reconfig_pulse_ff,
   output reg                     config_abort_ff,
   output reg                     cfg_bit_ff,
   output reg                     cfg_bit_valid_ff,
   input  wire [`ANA_BITS-1:0]    ana_probe,
   output reg  [`ANA_BITS-1:0]    ana_ctrl_ff
);
   localparam SW = 3 + `NUM_PINS;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   // three stages; a change is taken once stages two and three agree,
   // which also rejects single-sample glitches on the test clock
   reg  [SW-1:0] sync1_ff;
   reg  [SW-1:0] sync2_ff;
   reg  [SW-1:0] sync3_ff;
   reg  [SW-1:0] filt_ff;
   wire [SW-1:0] agree     = ~(sync2_ff ^ sync3_ff);
   wire [SW-1:0] nxt_filt  = (agree & sync3_ff) | (~agree & filt_ff);

   always @(posedge clk) begin
      if (!resetn) begin
         sync1_ff <= {SW{1'b0}};
         sync2_ff <= {SW{1'b0}};
         sync3_ff <= {SW{1'b0}};
         filt_ff  <= {SW{1'b0}};
      end else begin
         sync1_ff <= {pin_in, tdi, tms, tck};
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
         filt_ff  <= nxt_filt;
      end
   end

   wire                 tck_rise = nxt_filt[0] & ~filt_ff[0];
   wire                 tck_fall = ~nxt_filt[0] & filt_ff[0];
   wire                 tms_s    = filt_ff[1];
   wire                 tdi_s    = filt_ff[2];
   wire [`NUM_PINS-1:0] pins_s   = filt_ff[SW-1:3];

   // ----------------------------------------------------------------
   // controller
   // ----------------------------------------------------------------
   wire [3:0] state;

   tap_state_machine u_fsm (
      .clk      (clk),
      .resetn   (resetn),
      .tck_rise (tck_rise),
      .tms      (tms_s),
      .state_ff (state)
   );

   // ----------------------------------------------------------------
   // instruction register
   // ----------------------------------------------------------------
   reg [`IR_LEN-1:0] ir_sh_ff;
   reg [`IR_LEN-1:0] ir_ff;

   always @(posedge clk) begin
      if (!resetn) begin
         ir_sh_ff <= `IR_CAPTURE;
         ir_ff    <= `IR_IDCODE;
      end else begin
         if (tck_rise && state == `ST_CAP_IR)
            ir_sh_ff <= `IR_CAPTURE;
         else if (tck_rise && state == `ST_SHIFT_IR)
            ir_sh_ff <= {tdi_s, ir_sh_ff[`IR_LEN-1:1]}; // R17
         if (state == `ST_RESET)
            ir_ff <= `IR_IDCODE;
         else if (tck_fall && state == `ST_UPD_IR)
            ir_ff <= ir_sh_ff; // R20
      end
   end

   wire is_extest = (ir_ff == `IR_EXTEST);
   wire is_sample = (ir_ff == `IR_SAMPLE);
   wire is_clamp  = (ir_ff == `IR_CLAMP);
   wire is_highz  = (ir_ff == `IR_HIGHZ);
   wire is_id     = (ir_ff == `IR_IDCODE);
   wire is_user   = (ir_ff == `IR_USERCODE);
   wire is_icr    = (ir_ff == `IR_ICR);
   wire is_cfgio  = (ir_ff == `IR_CONFIG_IO);
   wire is_ana    = (ir_ff == `IR_ANALYZER);
   wire is_bsr    = is_extest | is_sample;

   // ----------------------------------------------------------------
   // data register path
   // ----------------------------------------------------------------
   // one shared shifter; its live length follows the instruction, so
   // every register shifts in at its own top bit
   reg [5:0]  dr_len;
   reg [31:0] dr_ff;
   reg [31:0] top_mask;
   reg [31:0] cap_val;

   always @* begin
      if (is_bsr)
         dr_len = config_done ? `BSR_CORE_LEN : `BSR_FULL_LEN; // R5
      else if (is_id || is_user)
         dr_len = `LEN_WORD; // R9 R10
      else if (is_cfgio)
         dr_len = `LEN_IOSTD; // R4
      else if (is_ana)
         dr_len = `LEN_ANA; // R16
      else
         dr_len = `LEN_ONE; // R8 R11 R12
      top_mask = 32'h0000_0001 << (dr_len - 6'd1);
   end

   // per pin: boundary cells (input, output, enable) and the pad drive
   reg  [3*`NUM_PINS-1:0] bsr_upd_ff;
   wire [3*`NUM_PINS-1:0] bsr_cells;
   wire [`NUM_PINS-1:0]   nxt_out;
   wire [`NUM_PINS-1:0]   nxt_oe;
   wire [31:0]            bsr_cap = {16'h0000, pll_cfg_ff, bsr_cells}; // R5
   genvar                 g;

   generate
      for (g = 0; g < `NUM_PINS; g = g + 1) begin : g_pin
         assign bsr_cells[3*g]   = pins_s[g]; // R6 R7
         assign bsr_cells[3*g+1] = core_out[g];
         assign bsr_cells[3*g+2] = core_oe[g];
         // forced modes apply whatever the configuration state; otherwise
         // the user drives only after configuration
         assign nxt_out[g] = (is_extest | is_clamp) ? bsr_upd_ff[3*g+1] : // R7 R12
                             (is_highz ? 1'b0 : core_out[g]); // R11
         assign nxt_oe[g]  = (is_extest | is_clamp) ? bsr_upd_ff[3*g+2] :
                             (is_highz ? 1'b0 : (core_oe[g] & config_done)); // R11 R3
      end
   endgenerate

   always @* begin
      if (is_bsr)
         cap_val = bsr_cap;
      else if (is_id)
         cap_val = {`ID_VERSION, `ID_PART, `ID_MAKER, 1'b1}; // R18
      else if (is_user)
         cap_val = user_code; // R9
      else if (is_cfgio)
         cap_val = {28'h0000000, io_std_ff};
      else if (is_ana)
         cap_val = {24'h000000, ana_probe}; // R16
      else
         cap_val = 32'h0000_0000; // R8
   end

   wire [31:0] shifted = {tdi_s, dr_ff[31:1]};
   wire [31:0] nxt_dr  = (shifted & ~top_mask) | ({32{tdi_s}} & top_mask);

   always @(posedge clk) begin
      if (!resetn) begin
         dr_ff            <= 32'h0000_0000;
         bsr_upd_ff       <= {3*`NUM_PINS{1'b0}};
         pll_cfg_ff       <= {`PLL_BITS{1'b0}};
         io_std_ff        <= {`NUM_PINS{1'b0}};
         ana_ctrl_ff      <= {`ANA_BITS{1'b0}};
         cfg_bit_ff       <= 1'b0;
         cfg_bit_valid_ff <= 1'b0;
      end else begin
         cfg_bit_valid_ff <= 1'b0;
         if (tck_rise && state == `ST_CAP_DR)
            dr_ff <= cap_val;
         else if (tck_rise && state == `ST_SHIFT_DR) begin
            dr_ff <= nxt_dr;
            if (is_icr) begin
               cfg_bit_ff       <= tdi_s; // R15
               cfg_bit_valid_ff <= 1'b1;
            end
         end
         if (tck_fall && state == `ST_UPD_DR) begin
            if (is_bsr) begin
               bsr_upd_ff <= dr_ff[3*`NUM_PINS-1:0]; // R6
               if (!config_done)
                  pll_cfg_ff <= dr_ff[15:12]; // R5
            end
            if (is_cfgio)
               io_std_ff <= dr_ff[`NUM_PINS-1:0]; // R4 R14
            if (is_ana)
               ana_ctrl_ff <= dr_ff[`ANA_BITS-1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // test data out
   // ----------------------------------------------------------------
   // changes on the falling test clock so the host samples it just before the next fall
   always @(posedge clk) begin
      if (!resetn) begin
         tdo_ff    <= 1'b0;
         tdo_oe_ff <= 1'b0;
      end else if (tck_fall) begin
         tdo_ff    <= (state == `ST_SHIFT_IR) ? ir_sh_ff[0] : dr_ff[0]; // R1
         tdo_oe_ff <= (state == `ST_SHIFT_IR) || (state == `ST_SHIFT_DR);
      end
   end

   // ----------------------------------------------------------------
   // configuration side effects
   // ----------------------------------------------------------------
   wire ir_load = tck_fall && (state == `ST_UPD_IR);

   always @(posedge clk) begin
      if (!resetn) begin
         reconfig_pulse_ff <= 1'b0;
         config_abort_ff   <= 1'b0;
      end else begin
         reconfig_pulse_ff <= ir_load && (ir_sh_ff == `IR_RECONFIG); // R13
         config_abort_ff   <= ir_load && (ir_sh_ff == `IR_CONFIG_IO) && config_busy; // R14
      end
   end

   // ----------------------------------------------------------------
   // pad control
   // ----------------------------------------------------------------
   wire forced = is_extest | is_clamp | is_highz;

   always @(posedge clk) begin
      if (!resetn) begin
         pad_out_ff  <= {`NUM_PINS{1'b0}};
         pad_oe_ff   <= {`NUM_PINS{1'b0}}; // R3
         pad_keep_ff <= {`NUM_PINS{1'b0}};
      end else begin
         pad_out_ff  <= nxt_out;
         pad_oe_ff   <= nxt_oe;
         pad_keep_ff <= hold_en & ~nxt_oe & {`NUM_PINS{forced}}; // R19
      end
   end
endmodule // boundary_scan_test_port

// [core/tap_regs.vh]
// What this block does
// R1: standard boundary-scan test port behaviour provided
// R2: host scans only outside configuration; the port takes scans during configuration too, config io then aborts it
// R3: pins undriven until configured, inputs tolerated; extest and clamp drive the boundary pattern before configuration too
// R4: scan chain rewrites pin standards anytime
// R5: pll bits in chain only before configuration
// R6: sample captures pins, preload stores pattern
// R7: extest drives pattern, captures input pins
// R8: bypass is one stage tdi to tdo
// R9: usercode shifts 32-bit user code out
// R10: idcode shifts identification value out
// R11: highz selects bypass, floats every pin
// R12: clamp selects bypass, holds boundary levels
// R13: reconfig instruction pulses internal reconfiguration request
// R14: config io sets standards, aborts configuration
// R15: in-circuit configuration data accepted through port
// R16: analyzer instructions monitor internals; sample shared
// R17: instruction register is ten bits
// R18: idcode version, part, maker, lsb one
// R19: bus hold overrides forced high impedance
// R20: sixteen-state controller, instruction at update-ir
`ifndef TAP_REGS_VH
`define TAP_REGS_VH

// ----------------------------------------------------------------
// controller states
// ----------------------------------------------------------------
`define ST_RESET     4'h0
`define ST_IDLE      4'h1
`define ST_SEL_DR    4'h2
`define ST_CAP_DR    4'h3
`define ST_SHIFT_DR  4'h4
`define ST_EX1_DR    4'h5
`define ST_PAUSE_DR  4'h6
`define ST_EX2_DR    4'h7
`define ST_UPD_DR    4'h8
`define ST_SEL_IR    4'h9
`define ST_CAP_IR    4'ha
`define ST_SHIFT_IR  4'hb
`define ST_EX1_IR    4'hc
`define ST_PAUSE_IR  4'hd
`define ST_EX2_IR    4'he
`define ST_UPD_IR    4'hf

// ----------------------------------------------------------------
// instruction codes
// ----------------------------------------------------------------
`define IR_LEN        10
`define IR_CAPTURE    10'h001
`define IR_EXTEST     10'h000
`define IR_SAMPLE     10'h005
`define IR_IDCODE     10'h006
`define IR_USERCODE   10'h007
`define IR_CLAMP      10'h00a
`define IR_HIGHZ      10'h00b
`define IR_ICR        10'h00c
`define IR_RECONFIG   10'h001
`define IR_CONFIG_IO  10'h00d
`define IR_ANALYZER   10'h00e
`define IR_BYPASS     10'h3ff

// ----------------------------------------------------------------
// data register sizes and identification
// ----------------------------------------------------------------
`define NUM_PINS      4
`define PLL_BITS      4
`define ANA_BITS      8
`define BSR_CORE_LEN  6'd12
`define BSR_FULL_LEN  6'd16
`define LEN_ONE       6'd1
`define LEN_WORD      6'd32
`define LEN_IOSTD     6'd4
`define LEN_ANA       6'd8
// identification fields: arbitrary neutral values
`define ID_VERSION    4'h0
`define ID_PART       16'h1234
`define ID_MAKER      11'h055

`endif

// [core/tap_state_machine.v]
`timescale 1ns/1ps
`include "tap_regs.vh"
module tap_state_machine (
   input  wire       clk,
   input  wire       resetn,
   input  wire       tck_rise,
   input  wire       tms,
   output reg  [3:0] state_ff
);
   localparam RESET = `ST_RESET, IDLE = `ST_IDLE, SEL_DR = `ST_SEL_DR, CAP_DR = `ST_CAP_DR;
   localparam SH_DR = `ST_SHIFT_DR, EX1_DR = `ST_EX1_DR, PA_DR = `ST_PAUSE_DR, EX2_DR = `ST_EX2_DR;
   localparam UP_DR = `ST_UPD_DR, SEL_IR = `ST_SEL_IR, CAP_IR = `ST_CAP_IR, SH_IR = `ST_SHIFT_IR;
   localparam EX1_IR = `ST_EX1_IR, PA_IR = `ST_PAUSE_IR, EX2_IR = `ST_EX2_IR, UP_IR = `ST_UPD_IR;

   reg [3:0] nxt_state;

   // standard sixteen-state walk
   always @* begin // R20
      case (state_ff)
         RESET:   nxt_state = tms ? RESET  : IDLE;
         IDLE:    nxt_state = tms ? SEL_DR : IDLE;
         SEL_DR:  nxt_state = tms ? SEL_IR : CAP_DR;
         CAP_DR:  nxt_state = tms ? EX1_DR : SH_DR;
         SH_DR:   nxt_state = tms ? EX1_DR : SH_DR;
         EX1_DR:  nxt_state = tms ? UP_DR  : PA_DR;
         PA_DR:   nxt_state = tms ? EX2_DR : PA_DR;
         EX2_DR:  nxt_state = tms ? UP_DR  : SH_DR;
         UP_DR:   nxt_state = tms ? SEL_DR : IDLE;
         SEL_IR:  nxt_state = tms ? RESET  : CAP_IR;
         CAP_IR:  nxt_state = tms ? EX1_IR : SH_IR;
         SH_IR:   nxt_state = tms ? EX1_IR : SH_IR;
         EX1_IR:  nxt_state = tms ? UP_IR  : PA_IR;
         PA_IR:   nxt_state = tms ? EX2_IR : PA_IR;
         EX2_IR:  nxt_state = tms ? UP_IR  : SH_IR;
         UP_IR:   nxt_state = tms ? SEL_DR : IDLE;
         default: nxt_state = RESET;
      endcase
   end

   always @(posedge clk) begin
      if (!resetn)
         state_ff <= RESET;
      else if (tck_rise)
         state_ff <= nxt_state;
   end
endmodule // tap_state_machine

// [tb/tap_port_chk.sv]
`timescale 1ns/1ps
`include "tap_regs.vh"
module tap_port_chk (
   input wire       clk,
   input wire       resetn,
   input wire       tck,
   input wire       tdo_ff,
   input wire       tdo_oe_ff,
   input wire [3:0] hold_en,
   input wire [3:0] pad_oe_ff,
   input wire [3:0] pad_keep_ff,
   input wire [3:0] io_std_ff,
   input wire [3:0] pll_cfg_ff,
   input wire       config_done,
   input wire       config_busy,
   input wire       reconfig_pulse_ff,
   input wire       config_abort_ff,
   input wire       cfg_bit_valid_ff,
   input wire [7:0] ana_ctrl_ff
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   a_powerup_float: assert property ($rose(resetn) |-> pad_oe_ff == 4'h0 && !tdo_oe_ff)
      else $error("outputs driven right after reset");
   a_keep_hold_only: assert property ((pad_keep_ff & (pad_oe_ff | ~$past(hold_en))) == 4'h0)
      else $error("keeper active without hold or while driven");
   a_reconfig_single: assert property (reconfig_pulse_ff |=> !reconfig_pulse_ff)
      else $error("reconfiguration pulse too long");
   a_abort_when_busy: assert property (config_abort_ff |-> $past(config_busy) ##1 !config_abort_ff)
      else $error("abort without configuration or too long");
   a_cfg_bit_pulse: assert property (cfg_bit_valid_ff |=> !cfg_bit_valid_ff [*3])
      else $error("config bit strobe not a single pulse");
   a_tdo_at_fall: assert property (($changed(tdo_ff) || $changed(tdo_oe_ff)) |-> !$past(tck, 2))
      else $error("tdo moved after a rising test clock");
   a_pll_frozen: assert property (config_done && $past(config_done) |-> $stable(pll_cfg_ff))
      else $error("pll bits written after configuration");
   a_std_at_fall: assert property ($changed(io_std_ff) |-> !$past(tck, 2))
      else $error("io standard changed off the update fall");
   a_ana_steady_hi: assert property (tck [*3] |-> $stable(ana_ctrl_ff))
      else $error("analyzer control changed while clock high");

   c_reconfig: cover property (reconfig_pulse_ff);
   c_abort: cover property (config_abort_ff);
   c_keep: cover property (pad_keep_ff != 4'h0);
endmodule // tap_port_chk

// [tb/jtag_host.sv]
`timescale 1ns/1ps
module jtag_host (
   input  wire clk,
   input  wire tdo,
   output reg  tck,
   output reg  tms,
   output reg  tdi
);
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   // 8 clk per tck; tms/tdi move only while tck is low (at the fall, or before the first rise of a frame), tdo read just before the fall
   task frame(input [63:0] tv, input [63:0] dv, input integer n, output [63:0] ov);
      integer i;
      begin
         ov = 64'h0;
         for (i = 0; i < n; i = i + 1) begin
            tck <= 1'b0;
            tms <= tv[i];
            tdi <= dv[i];
            repeat (4) @(negedge clk);
            tck <= 1'b1;
            repeat (4) @(negedge clk);
            ov[i] = tdo;
         end
         tck <= 1'b0; // clock stands still between frames
         tdi <= ~dv[n-1]; // released line must not look held
         repeat (6) @(negedge clk);
      end
   endtask
   task tlr;
      reg [63:0] o;
      begin
         frame(64'h1f, 64'h0, 6, o);
      end
   endtask
   task load_ir(input [9:0] code, output [9:0] cap);
      reg [63:0] o;
      begin
         frame(64'hc006, {49'h0, code, 5'h0}, 17, o);
         cap = o[14:5];
      end
   endtask
   task dr(input integer n, input [31:0] d, output [31:0] q);
      reg [63:0] o;
      begin
         frame(64'h1 | (64'h3 << (n + 2)), {29'h0, d, 3'h0}, n + 5, o);
         q = o[34:3];
      end
   endtask
endmodule // jtag_host

// [tb/boundary_scan_test_port_bench.sv]
`timescale 1ns/1ps
`include "tap_regs.vh"
module boundary_scan_test_port_bench;
   reg         clk = 1'b0;
   reg         resetn = 1'b0;
   reg         config_done = 1'b0;
   reg         config_busy = 1'b0;
   reg  [3:0]  pin_in = 4'h6;
   reg  [3:0]  core_out = 4'h5;
   reg  [3:0]  core_oe = 4'h3;
   reg  [3:0]  hold_en = 4'hf;
   reg  [7:0]  ana_probe = 8'h3c;
   reg  [31:0] user_code = 32'h5a3c9e01;
   wire        tck, tms, tdi, tdo_ff, tdo_oe_ff, reconfig_pulse_ff, config_abort_ff, cfg_bit_ff, cfg_bit_valid_ff;
   wire [3:0]  pad_out_ff, pad_oe_ff, pad_keep_ff, io_std_ff, pll_cfg_ff;
   wire [7:0]  ana_ctrl_ff;
   integer     bad_count = 0, checked = 0, n_rc = 0, n_ab = 0, n_cv = 0, n_oe = 0, n;
   reg  [31:0] r;
   reg  [9:0]  cap;

   always #10 clk = ~clk;
   always @(posedge clk) begin
      if (resetn) begin
         n_rc <= n_rc + reconfig_pulse_ff;
         n_ab <= n_ab + config_abort_ff;
         n_cv <= n_cv + cfg_bit_valid_ff;
         n_oe <= n_oe + tdo_oe_ff;
      end
   end

   jtag_host host (.clk(clk), .tdo(tdo_ff), .tck(tck), .tms(tms), .tdi(tdi));
   boundary_scan_test_port uut (.clk(clk), .resetn(resetn), .tck(tck), .tms(tms), .tdi(tdi), .tdo_ff(tdo_ff),
      .tdo_oe_ff(tdo_oe_ff), .pin_in(pin_in), .core_out(core_out), .core_oe(core_oe), .hold_en(hold_en),
      .pad_out_ff(pad_out_ff), .pad_oe_ff(pad_oe_ff), .pad_keep_ff(pad_keep_ff), .io_std_ff(io_std_ff),
      .pll_cfg_ff(pll_cfg_ff), .config_done(config_done), .config_busy(config_busy), .user_code(user_code),
      .reconfig_pulse_ff(reconfig_pulse_ff), .config_abort_ff(config_abort_ff), .cfg_bit_ff(cfg_bit_ff),
      .cfg_bit_valid_ff(cfg_bit_valid_ff), .ana_probe(ana_probe), .ana_ctrl_ff(ana_ctrl_ff));

   task cmp(input [31:0] got, input [31:0] exp);
      begin
         checked = checked + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task cmp4(input [3:0] got, input [3:0] exp);
      begin
         cmp({28'h0, got}, {28'h0, exp});
      end
   endtask
   task end_of_test;
      begin
         $display("checks %0d mismatches %0d", checked, bad_count);
         if (bad_count == 0 && checked > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   // ----
   // scenarios
   // ----
   task ld(input [9:0] code);
      begin
         host.load_ir(code, cap);
         cmp({22'h0, cap}, 32'h1);
      end
   endtask
   task pass_thru;
      integer m;
      begin
         m = n_oe;
         host.dr(9, 32'hb5, r);
         cmp(r & 32'h1ff, 32'h16a);
         cmp(n_oe - m, 32'd72);
      end
   endtask
   task bsr(input integer len, input [3:0] po, input [3:0] oe, input [3:0] pl);
      reg [31:0] d;
      reg [3:0]  g;
      integer    i;
      begin
         d = {16'h0, pl, 12'h0};
         for (i = 0; i < 4; i = i + 1) begin
            d[3*i+1] = po[i];
            d[3*i+2] = oe[i];
         end
         host.dr(len, d, r);
         for (i = 0; i < 4; i = i + 1)
            g[i] = r[3*i];
         cmp4(g, pin_in);
      end
   endtask
   task s_ident;
      begin
         host.tlr;
         host.dr(32, 32'h0, r);
         cmp(r, {`ID_VERSION, `ID_PART, `ID_MAKER, 1'b1});
         ld(`IR_USERCODE);
         host.dr(32, 32'h0, r);
         cmp(r, user_code);
      end
   endtask
   task s_bypass;
      begin
         ld(`IR_BYPASS);
         pass_thru;
         ld(10'h2a5);
         pass_thru;
      end
   endtask
   task s_extest;
      begin
         ld(`IR_EXTEST);
         bsr(16, 4'ha, 4'h3, 4'h9);
         cmp4(pad_out_ff, 4'ha);
         cmp4(pad_oe_ff, 4'h3);
         cmp4(pad_keep_ff, 4'hc);
         cmp4(pll_cfg_ff, 4'h9);
      end
   endtask
   task s_configured;
      begin
         config_done = 1'b1;
         pin_in = 4'h9;
         ld(`IR_SAMPLE);
         bsr(12, 4'h6, 4'hf, 4'h0);
         cmp4(pad_out_ff, core_out);
         cmp4(pad_oe_ff, core_oe);
         cmp4(pll_cfg_ff, 4'h9);
         ld(`IR_CLAMP);
         pass_thru;
         cmp4(pad_out_ff, 4'h6);
         cmp4(pad_oe_ff, 4'hf);
         hold_en = 4'h5;
         ld(`IR_HIGHZ);
         pass_thru;
         cmp4(pad_oe_ff, 4'h0);
         cmp4(pad_keep_ff, 4'h5);
      end
   endtask
   task s_special;
      begin
         n = n_ab;
         config_busy = 1'b1;
         ld(`IR_CONFIG_IO);
         cmp(n_ab - n, 32'h1);
         config_busy = 1'b0;
         host.dr(4, 32'h9, r);
         cmp4(io_std_ff, 4'h9);
         n = n_rc;
         ld(`IR_RECONFIG);
         cmp(n_rc - n, 32'h1);
         n = n_cv;
         ld(`IR_ICR);
         host.dr(3, 32'h5, r);
         cmp(n_cv - n, 32'h3);
         cmp({31'h0, cfg_bit_ff}, 32'h1);
         ld(`IR_ANALYZER);
         host.dr(8, 32'ha7, r);
         cmp(r & 32'hff, {24'h0, ana_probe});
         cmp({24'h0, ana_ctrl_ff}, 32'ha7);
      end
   endtask

   initial begin
      repeat (20) @(negedge clk);
      resetn = 1'b1;
      repeat (4) @(negedge clk);
      cmp4(pad_oe_ff, 4'h0);
      cmp({31'h0, tdo_oe_ff}, 32'h0);
      s_ident;
      s_bypass;
      s_extest;
      s_configured;
      s_special;
      end_of_test;
   end
endmodule // boundary_scan_test_port_bench

bind boundary_scan_test_port tap_port_chk chk (.clk(clk), .resetn(resetn), .tck(tck), .tdo_ff(tdo_ff),
   .tdo_oe_ff(tdo_oe_ff), .hold_en(hold_en), .pad_oe_ff(pad_oe_ff), .pad_keep_ff(pad_keep_ff),
   .io_std_ff(io_std_ff), .pll_cfg_ff(pll_cfg_ff), .config_done(config_done), .config_busy(config_busy),
   .reconfig_pulse_ff(reconfig_pulse_ff), .config_abort_ff(config_abort_ff),
   .cfg_bit_valid_ff(cfg_bit_valid_ff), .ana_ctrl_ff(ana_ctrl_ff));
